// >>> src/cra_pkg.sv
package cra_pkg;

   localparam int unsigned CRA_WORD_W = 32;
   localparam int unsigned CRA_CMD_W = 8;
   localparam int unsigned CRA_NCH = 4;

   // Command byte field positions
   localparam int unsigned CRA_POS_CMD_BIT = 7;
   localparam int unsigned CRA_POS_ARRAY = 6;
   localparam int unsigned CRA_POS_CS_HIGH = 5;
   localparam int unsigned CRA_POS_CS_LOW = 4;
   localparam int unsigned CRA_POS_RW = 3;

   // Register select codes in D2..D0
   localparam logic [2:0] CRA_RS_OFFSET = 3'h1;
   localparam logic [2:0] CRA_RS_GAIN = 3'h2;
   localparam logic [2:0] CRA_RS_SETUP = 3'h5;

   // Bit and channel counter limits
   localparam logic [4:0] CRA_CMD_LAST_BIT = 5'h07;
   localparam logic [4:0] CRA_WORD_LAST_BIT = 5'h1f;
   localparam logic [1:0] CRA_CH_LAST_TWO = 2'h1;
   localparam logic [1:0] CRA_CH_LAST_FOUR = 2'h3;

   // Values after reset
   localparam logic [31:0] CRA_OFFSET_RST = 32'h00000000;
   localparam logic [31:0] CRA_GAIN_RST = 32'h0100000;
   localparam logic [31:0] CRA_SETUP_RST = 32'h00000000;

   typedef enum logic [1:0] {
      CRA_KIND_NONE = 2'h0,
      CRA_KIND_OFFSET = 2'h1,
      CRA_KIND_GAIN = 2'h2,
      CRA_KIND_SETUP = 2'h3
   } cra_kind_e;

   typedef enum logic [1:0] {
      CRA_ST_CMD = 2'h0,
      CRA_ST_XFER = 2'h1
   } cra_state_e;

   typedef struct packed {
      logic valid;
      logic array_access_flag;
      logic read;
      logic [1:0] chan;
      cra_kind_e kind;
   } cra_cmd_s;

   typedef struct packed {
      logic [3:0][31:0] offset;
      logic [3:0][31:0] gain;
      logic [3:0][31:0] setup;
   } cra_regs_s;

endpackage : cra_pkg

// >>> src/cra_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none

module cra_cmd_decode (
   input wire logic [7:0] cmd_byte_in, // Command byte, D7 first received
   output cra_pkg::cra_cmd_s dec_out // Decoded access
);

   wire logic [2:0] rs_sel;
   wire logic array_access_flag;
   wire logic [1:0] chan_sel;
   wire logic chans_clear;
   wire logic cmd_bit;
   cra_pkg::cra_kind_e kind;

   assign rs_sel = cmd_byte_in[2:0];
   assign cmd_bit = cmd_byte_in[cra_pkg::CRA_POS_CMD_BIT];
   assign array_access_flag = cmd_byte_in[cra_pkg::CRA_POS_ARRAY];
   // R01 selector in D5..D4
   assign chan_sel = {cmd_byte_in[cra_pkg::CRA_POS_CS_HIGH], cmd_byte_in[cra_pkg::CRA_POS_CS_LOW]};
   assign chans_clear = (chan_sel == 2'h0);
   // R07 R08 R11 select codes
   assign kind = (rs_sel == cra_pkg::CRA_RS_OFFSET) ? cra_pkg::CRA_KIND_OFFSET :
                 (rs_sel == cra_pkg::CRA_RS_GAIN) ? cra_pkg::CRA_KIND_GAIN :
                 (rs_sel == cra_pkg::CRA_RS_SETUP) ? cra_pkg::CRA_KIND_SETUP :
                 cra_pkg::CRA_KIND_NONE;

   // Array form needs the channel bits at zero
   assign dec_out.valid = !cmd_bit && (kind != cra_pkg::CRA_KIND_NONE) && (!array_access_flag || chans_clear);
   assign dec_out.array_access_flag = array_access_flag;
   assign dec_out.read = cmd_byte_in[cra_pkg::CRA_POS_RW];
   assign dec_out.chan = array_access_flag ? 2'h0 : chan_sel;
   assign dec_out.kind = kind;

endmodule : cra_cmd_decode

`default_nettype wire

// >>> src/cra_access.sv
// Operation
// R01 - Individual commands carry the channel selector in D5 and D4.
// R02 - Offset selector 00 and 01 reach offset registers one and two.
// R03 - Offset selector 10 and 11 reach registers three and four, four-channel only.
// R04 - Gain selector 00 and 01 reach gain registers one and two.
// R05 - Gain selector 10 and 11 reach gain three and four, four-channel only.
// R06 - Read bit set returns the selected register instead of storing.
// R07 - Individual gain byte is 00, selector, read bit, then 010.
// R08 - Array offset byte is 0, 1, 00, read bit, then 001.
// R09 - Array access moves every channel, MSB first, channel 0 upward.
// R10 - After reset wait for command; first eight bits form the command.
// R11 - Array setup byte is 0, 1, 00, read bit, then 101.
// R12 - Read bit clear stores following host words into selected registers.
`timescale 1ns/1ps
`default_nettype none

module cra_access (
   input wire logic clock_in, // 200 MHz
   input wire logic rst_b_in, // Async reset, active low
   input wire logic bit_valid_in, // One serial bit shifted in
   input wire logic bit_data_in, // Value of that bit
   input wire logic four_channel_in, // Strap: four-channel variant
   output logic sdo_bit_out, // Bit for host to shift out, MSB first
   output logic sdo_en_out, // High while read data is presented
   output logic busy_out, // Data phase in progress
   output logic cmd_accept_out, // Pulse: command taken
   output logic cmd_reject_out, // Pulse: command not handled here
   output cra_pkg::cra_regs_s regs_out // Calibration and setup registers
);

   cra_pkg::cra_state_e state_r, state_nxt;
   cra_pkg::cra_cmd_s cmd_r, cmd_nxt;
   cra_pkg::cra_cmd_s dec;
   cra_pkg::cra_regs_s regs_r, regs_nxt;
   logic [7:0] cmd_sh_r;
   logic [4:0] bit_cnt_r;
   logic [1:0] ch_r, ch_nxt;
   logic [31:0] shift_r, shift_nxt;
   logic four_meta_r, four_r;
   logic accept_r, reject_r, sdo_en_r;
   wire logic [7:0] cmd_byte;
   wire logic [31:0] word_in;
   wire logic in_cmd;
   wire logic in_xfer;
   wire logic cmd_done;
   wire logic word_done;
   wire logic last_word;
   wire logic [1:0] last_ch;
   wire logic ch_exists;

   // Reads of an absent channel return zero
   function automatic logic [31:0] rd_word(input cra_pkg::cra_regs_s regs, input cra_pkg::cra_kind_e kind,
                                           input logic [1:0] ch, input logic four);
      logic [31:0] w;
      w = 32'h00000000;
      // R02 R04 selector picks register
      if (four || !ch[1])
      begin
         unique case (kind)
            cra_pkg::CRA_KIND_OFFSET: w = regs.offset[ch];
            cra_pkg::CRA_KIND_GAIN: w = regs.gain[ch];
            cra_pkg::CRA_KIND_SETUP: w = regs.setup[ch];
            default: w = 32'h00000000;
         endcase
      end
      return w;
   endfunction : rd_word

   cra_cmd_decode u_decode (
      .cmd_byte_in(cmd_byte),
      .dec_out(dec)
   );

   // Strap arrives from a pin, so two flops first
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         four_meta_r <= 1'b0;
         four_r <= 1'b0;
      end
      else
      begin
         four_meta_r <= four_channel_in;
         four_r <= four_meta_r;
      end
   end

   // R10 first eight bits
   assign in_cmd = (state_r == cra_pkg::CRA_ST_CMD);
   assign in_xfer = (state_r == cra_pkg::CRA_ST_XFER);
   assign cmd_byte = {cmd_sh_r[6:0], bit_data_in};
   assign cmd_done = in_cmd && bit_valid_in && (bit_cnt_r == cra_pkg::CRA_CMD_LAST_BIT);
   assign word_in = {shift_r[30:0], bit_data_in};
   assign word_done = in_xfer && bit_valid_in && (bit_cnt_r == cra_pkg::CRA_WORD_LAST_BIT);
   // R09 channel count
   assign last_ch = four_r ? cra_pkg::CRA_CH_LAST_FOUR : cra_pkg::CRA_CH_LAST_TWO;
   assign last_word = !cmd_r.array_access_flag || (ch_r == last_ch);
   // R03 R05 upper pair only on four channels
   assign ch_exists = four_r || !ch_r[1];

   always_comb
   begin
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      ch_nxt = ch_r;
      shift_nxt = shift_r;
      regs_nxt = regs_r;
      if (cmd_done && dec.valid)
      begin
         state_nxt = cra_pkg::CRA_ST_XFER;
         cmd_nxt = dec;
         // R01 channel from D5..D4
         ch_nxt = dec.chan;
         // R06 preload selected word
         shift_nxt = dec.read ? rd_word(regs_r, dec.kind, dec.chan, four_r) : 32'h00000000;
      end
      else if (in_xfer && bit_valid_in)
      begin
         // R09 MSB first
         shift_nxt = cmd_r.read ? {shift_r[30:0], 1'b0} : word_in;
         if (word_done)
         begin
            // R12 store written word
            if (!cmd_r.read && ch_exists)
            begin
               unique case (cmd_r.kind)
                  cra_pkg::CRA_KIND_OFFSET: regs_nxt.offset[ch_r] = word_in;
                  cra_pkg::CRA_KIND_GAIN: regs_nxt.gain[ch_r] = word_in;
                  cra_pkg::CRA_KIND_SETUP: regs_nxt.setup[ch_r] = word_in;
                  default: regs_nxt = regs_r;
               endcase
            end
            if (last_word)
            begin
               state_nxt = cra_pkg::CRA_ST_CMD;
            end
            else
            begin
               // R09 next channel upward
               ch_nxt = ch_r + 2'h1;
               shift_nxt = cmd_r.read ? rd_word(regs_r, cmd_r.kind, ch_r + 2'h1, four_r) : 32'h00000000;
            end
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_r <= cra_pkg::CRA_ST_CMD;
         cmd_r <= '0;
         ch_r <= 2'h0;
         shift_r <= 32'h00000000;
         cmd_sh_r <= 8'h00;
         bit_cnt_r <= 5'h00;
         accept_r <= 1'b0;
         reject_r <= 1'b0;
         sdo_en_r <= 1'b0;
         regs_r.offset <= {cra_pkg::CRA_NCH{cra_pkg::CRA_OFFSET_RST}};
         regs_r.gain <= {cra_pkg::CRA_NCH{cra_pkg::CRA_GAIN_RST}};
         regs_r.setup <= {cra_pkg::CRA_NCH{cra_pkg::CRA_SETUP_RST}};
      end
      else
      begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         ch_r <= ch_nxt;
         shift_r <= shift_nxt;
         regs_r <= regs_nxt;
         cmd_sh_r <= (in_cmd && bit_valid_in) ? cmd_byte : cmd_sh_r;
         // Counter wraps at 8 in command phase, at 32 in data phase
         bit_cnt_r <= (cmd_done || word_done) ? 5'h00 : (bit_valid_in ? bit_cnt_r + 5'h01 : bit_cnt_r);
         accept_r <= cmd_done && dec.valid;
         reject_r <= cmd_done && !dec.valid;
         // R06 read data phase, registered so the pin is glitch free
         sdo_en_r <= (state_nxt == cra_pkg::CRA_ST_XFER) && cmd_nxt.read;
      end
   end

   assign sdo_bit_out = shift_r[31];
   assign sdo_en_out = sdo_en_r;
   assign busy_out = state_r[0];
   assign cmd_accept_out = accept_r;
   assign cmd_reject_out = reject_r;
   assign regs_out = regs_r;

   chan_field_a: assert property ( // R01
      @(posedge clock_in) disable iff (!rst_b_in)
      cmd_done && dec.valid && !cmd_byte[6] |=> ch_r == $past(cmd_byte[5:4]))
      else $error("channel selector not taken from D5..D4");

   offset_low_a: assert property ( // R02
      @(posedge clock_in) disable iff (!rst_b_in)
      cmd_done && cmd_byte == 8'h19 |=> shift_r == $past(regs_r.offset[1]))
      else $error("offset selector 01 read wrong register");

   offset_high_a: assert property ( // R03
      @(posedge clock_in) disable iff (!rst_b_in)
      cmd_done && cmd_byte == 8'h29 |=> shift_r == ($past(four_r) ? $past(regs_r.offset[2]) : 32'h00000000))
      else $error("offset selector 10 wrong for variant");

   gain_low_a: assert property ( // R04
      @(posedge clock_in) disable iff (!rst_b_in)
      cmd_done && cmd_byte == 8'h0a |=> shift_r == $past(regs_r.gain[0]) && sdo_en_out)
      else $error("gain selector 00 read wrong register");

   gain_high_a: assert property ( // R05
      @(posedge clock_in) disable iff (!rst_b_in)
      word_done && !cmd_r.read && cmd_r.kind == cra_pkg::CRA_KIND_GAIN && ch_r == 2'h3 && !four_r
      |=> $stable(regs_r.gain))
      else $error("gain register four written on two-channel part");

   read_hold_a: assert property ( // R06
      @(posedge clock_in) disable iff (!rst_b_in)
      in_xfer && cmd_r.read |=> $stable(regs_r))
      else $error("register changed during read");

   gain_decode_a: assert property ( // R07
      @(posedge clock_in) disable iff (!rst_b_in)
      cmd_done && cmd_byte[7:6] == 2'h0 && cmd_byte[2:0] == 3'h2
      |=> busy_out && cmd_r.kind == cra_pkg::CRA_KIND_GAIN && !cmd_r.array_access_flag)
      else $error("individual gain byte not decoded");

   offset_array_a: assert property ( // R08
      @(posedge clock_in) disable iff (!rst_b_in)
      cmd_done && cmd_byte == 8'h41 |=> cmd_accept_out && cmd_r.array_access_flag && ch_r == 2'h0)
      else $error("array offset byte not decoded");

   array_step_a: assert property ( // R09
      @(posedge clock_in) disable iff (!rst_b_in)
      word_done && cmd_r.array_access_flag && !last_word |=> busy_out && ch_r == $past(ch_r) + 2'h1)
      else $error("array channel did not advance");

   cmd_byte_a: assert property ( // R10
      @(posedge clock_in) disable iff (!rst_b_in)
      cmd_done |=> busy_out || cmd_reject_out)
      else $error("eighth bit did not complete command");

   setup_array_a: assert property ( // R11
      @(posedge clock_in) disable iff (!rst_b_in)
      cmd_done && cmd_byte == 8'h4d |=> sdo_en_out && cmd_r.kind == cra_pkg::CRA_KIND_SETUP)
      else $error("array setup read byte not decoded");

   write_store_a: assert property ( // R12
      @(posedge clock_in) disable iff (!rst_b_in)
      word_done && !cmd_r.read && cmd_r.kind == cra_pkg::CRA_KIND_OFFSET && ch_r == 2'h1
      |=> regs_r.offset[1] == $past(word_in))
      else $error("offset word not stored");

endmodule : cra_access

`default_nettype wire

// >>> verif/cra_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module cra_host_model (
   input wire logic clock_in, // Bench clock
   input wire logic sdo_bit_in, // Read bit from the device
   output logic bit_valid_out, // One pulse per bit
   output logic bit_data_out // Bit value
);
   initial
   begin
      bit_valid_out = 1'b0;
      bit_data_out = 1'b0;
   end

   // bits MSB first, idle edge before each group
   task send(input logic [31:0] v, input int n);
      // Idle edge keeps a strobe drop and raise apart
      @(posedge clock_in);
      #1;
      for (int i = n - 1; i >= 0; i--)
      begin
         bit_valid_out = 1'b1;
         bit_data_out = v[i];
         @(posedge clock_in);
         #1;
      end
      bit_valid_out = 1'b0;
      // Released line must not keep a stale value
      bit_data_out = ~bit_data_out;
   endtask : send

   task rd(output logic [31:0] v);
      @(posedge clock_in);
      #1;
      for (int i = 31; i >= 0; i--)
      begin
         v[i] = sdo_bit_in;
         bit_valid_out = 1'b1;
         bit_data_out = ~bit_data_out;
         @(posedge clock_in);
         #1;
      end
      bit_valid_out = 1'b0;
   endtask : rd
endmodule : cra_host_model

`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic clock_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic four_channel_in = 1'b1;
   logic bit_valid;
   logic bit_data;
   logic sdo_bit_out;
   logic sdo_en_out;
   logic busy_out;
   logic cmd_accept_out;
   logic cmd_reject_out;
   cra_pkg::cra_regs_s regs_out;
   logic [31:0] mdl [3][4];
   logic [2:0] rs_code [3];
   logic [7:0] bad_cmd [4];
   integer seed = 25;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;

   always #2.5 clock_in = ~clock_in;

   cra_access DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .bit_valid_in(bit_valid),
      .bit_data_in(bit_data), .four_channel_in(four_channel_in), .sdo_bit_out(sdo_bit_out),
      .sdo_en_out(sdo_en_out), .busy_out(busy_out), .cmd_accept_out(cmd_accept_out),
      .cmd_reject_out(cmd_reject_out), .regs_out(regs_out));

   cra_host_model host (.clock_in(clock_in), .sdo_bit_in(sdo_bit_out), .bit_valid_out(bit_valid),
      .bit_data_out(bit_data));

   task close_out;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out

   // Run is a few thousand cycles; a hang goes far past this
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         close_out();
      end
   end

   task chk32(input string name, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask : chk32

   task chk1(input string name, input logic e, input logic g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", name, e, g);
      end
   endtask : chk1

   task regs_cmp;
      for (int c = 0; c < 4; c++)
      begin
         chk32("offset reg", mdl[0][c], regs_out.offset[c]);
         chk32("gain reg", mdl[1][c], regs_out.gain[c]);
         chk32("setup reg", mdl[2][c], regs_out.setup[c]);
      end
   endtask : regs_cmp

   // Kind k: 0 offset, 1 gain, 2 setup
   task run(input int k, input logic arr, input logic [1:0] ch, input logic rd);
      logic [31:0] v;
      int n;
      int c;
      host.send({1'b0, arr, ch, rd, rs_code[k]}, 8);
      chk1("accept", 1'b1, cmd_accept_out);
      chk1("busy", 1'b1, busy_out);
      chk1("sdo_en", rd, sdo_en_out);
      n = arr ? (four_channel_in ? 4 : 2) : 1;
      for (int i = 0; i < n; i++)
      begin
         c = arr ? i : int'(ch);
         if (rd)
         begin
            host.rd(v);
            chk32("read word", (four_channel_in || c < 2) ? mdl[k][c] : 32'h0, v);
         end
         else
         begin
            v = $random(seed);
            host.send(v, 32);
            if (four_channel_in || c < 2)
               mdl[k][c] = v;
         end
      end
      chk1("busy end", 1'b0, busy_out);
      regs_cmp();
   endtask : run

   task rej(input logic [7:0] cmd);
      host.send({24'h000000, cmd}, 8);
      chk1("reject", 1'b1, cmd_reject_out);
      chk1("no accept", 1'b0, cmd_accept_out);
      chk1("no busy", 1'b0, busy_out);
   endtask : rej

   initial
   begin
      rs_code = '{cra_pkg::CRA_RS_OFFSET, cra_pkg::CRA_RS_GAIN, cra_pkg::CRA_RS_SETUP};
      // Set bit, config code, array with channel bits, reserved code
      bad_cmd = '{8'h8a, 8'h0b, 8'h5a, 8'h00};
      for (int c = 0; c < 4; c++)
      begin
         mdl[0][c] = cra_pkg::CRA_OFFSET_RST;
         mdl[1][c] = cra_pkg::CRA_GAIN_RST;
         mdl[2][c] = cra_pkg::CRA_SETUP_RST;
      end
      repeat (20) @(posedge clock_in);
      #1;
      rst_b_in = 1'b1;
      run(1, 1'b0, 2'h0, 1'b1);
      for (int f = 1; f >= 0; f--)
      begin
         four_channel_in = f[0];
         repeat (3) @(posedge clock_in);
         #1;
         for (int k = 0; k < 2; k++)
            for (int ch = 0; ch < 4; ch++)
            begin
               run(k, 1'b0, ch[1:0], 1'b0);
               run(k, 1'b0, ch[1:0], 1'b1);
            end
         for (int k = 0; k < 3; k++)
         begin
            run(k, 1'b1, 2'h0, 1'b0);
            run(k, 1'b1, 2'h0, 1'b1);
         end
      end
      for (int i = 0; i < 4; i++)
         rej(bad_cmd[i]);
      run(2, 1'b1, 2'h0, 1'b1);
      close_out();
   end
endmodule : testbench

`default_nettype wire
